// ===== dv/qad_host_model.sv
// Host controller model for the converter serial frame.
// Assumes the bench sets addr and calls run_frame; sclk parks low.
`timescale 1ns/1ps
module qad_host_model
(
  // Serial link
  output logic sclk,
  output logic cs_n,
  output logic din,
  input wire logic dout,
  input wire logic dout_oe,
  // Observation only
  input wire logic track
);
  localparam time HALF = 40ns;
  logic [15:0] rx [2];
  logic [15:0] trk [2];
  logic [1:0] addr [2];
  logic oe_ok;
  // Idle: select high, clock still and low
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
  end
  // Whole groups unless an abort is wanted; phase kept off ref_clk
  task automatic run_frame(input int nclk);
    int g;
    int e;
    #1.3ns;
    oe_ok = 1'b1;
    cs_n = 1'b0;
    #HALF;
    for (int i = 0; i < nclk; i++)
    begin
      g = (i / 16) % 2;
      e = i % 16 + 1;
      sclk = 1'b1;
      rx[g][16-e] = dout_oe ? dout : ~dout;
      trk[g][16-e] = track;
      oe_ok = oe_ok & dout_oe;
      #HALF;
      sclk = 1'b0;
      // Address bits ahead of rising 4 and 5, else a toggling line
      din = (e == 3) ? addr[g][1] : (e == 4) ? addr[g][0] : ~din;
      #HALF;
    end
    cs_n = 1'b1;
  endtask : run_frame
endmodule : qad_host_model

// ===== dv/testbench.sv
// Self-checking bench for the converter serial frame logic.
// Assumes the host model owns sclk; the bench acts as front end.
`timescale 1ns/1ps
module testbench;
  import qad_pkg::*;
  logic ref_clk, reset_n, sclk, cs_n, din, dout, dout_oe, track;
  logic [DATA_BITS-1:0] conv_code;
  qad_core_stat_type core_stat;
  logic [7:0] code_tab [4] = '{8'h00, 8'hFF, 8'hA5, 8'h3C};
  logic [1:0] prev_ch;
  int mismatches, compares;
  qad_serial_frame i_qad_serial_frame (.ref_clk(ref_clk),
    .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
    .dout_oe(dout_oe), .conv_code(conv_code), .core_stat(core_stat),
    .track(track));
  qad_host_model i_qad_host_model (.sclk(sclk), .cs_n(cs_n), .din(din),
    .dout(dout), .dout_oe(dout_oe), .track(track));
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5ns ref_clk = ~ref_clk;
  end
  // Front end returns the code of whichever channel is selected
  always @(posedge ref_clk)
    conv_code <= code_tab[core_stat.mux_sel];
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize;
    if (mismatches == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize
  // Gap between frames: line released, core shut down
  task automatic gap;
    repeat (40) @(posedge ref_clk);
    check(dout_oe, 1'b0);
    check(core_stat.power_down, 1'b1);
  endtask : gap
  // One group per frame, every channel, both code extremes
  task automatic scen_channels;
    for (int i = 0; i < 5; i++)
    begin
      i_qad_host_model.addr[0] = i[1:0];
      i_qad_host_model.run_frame(16);
      check(i_qad_host_model.rx[0], {4'h0, code_tab[prev_ch], 4'h0});
      check(i_qad_host_model.trk[0], 16'hF000);
      check(i_qad_host_model.oe_ok, 1'b1);
      prev_ch = i[1:0];
      gap();
    end
  endtask : scen_channels
  // Two groups back to back; the second uses the first's address
  task automatic scen_two_groups;
    i_qad_host_model.addr[0] = 2'h2;
    i_qad_host_model.addr[1] = 2'h1;
    fork
      i_qad_host_model.run_frame(32);
      #600ns check(core_stat.power_down, 1'b0);
    join
    check(i_qad_host_model.rx[0], {4'h0, code_tab[prev_ch], 4'h0});
    check(i_qad_host_model.rx[1], {4'h0, code_tab[2], 4'h0});
    check(i_qad_host_model.trk[1], 16'hF000);
    gap();
  endtask : scen_two_groups
  // Abort in mid group, then a clean frame keeps its framing
  task automatic scen_abort;
    i_qad_host_model.addr[0] = 2'h3;
    i_qad_host_model.run_frame(8);
    gap();
    i_qad_host_model.addr[0] = 2'h0;
    i_qad_host_model.run_frame(16);
    check(i_qad_host_model.rx[0] & 16'hF00F, 16'h0000);
    check(i_qad_host_model.rx[0], {4'h0, code_tab[3], 4'h0});
    check(i_qad_host_model.trk[0], 16'hF000);
    gap();
  endtask : scen_abort
  initial
  begin
    reset_n = 1'b0;
    prev_ch = 2'h0;
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    gap();
    scen_channels();
    scen_two_groups();
    scen_abort();
    summarize();
  end
  // Whole run needs about 13 us; cut a hang well beyond that
  initial
  begin
    #100us;
    mismatches++;
    summarize();
  end
endmodule : testbench

// ===== hw/qad_pkg.sv
// Constants and carrier types for the quad channel converter serial frame.
// Assumes one frame logic instance per converter, 8-bit straight binary.
package qad_pkg;

  // Frame shape in serial clock periods
  localparam int FRAME_CLKS = 16;
  localparam int TRACK_CLKS = 3;
  localparam int CONV_CLKS = 13;
  localparam int DATA_BITS = 8;
  localparam int LEAD_ZEROS = 4;
  localparam int CH_BITS = 2;
  localparam int CNT_BITS = 4;

  // Rising edges that carry the next channel address, counted from one
  localparam int ADDR_FIRST_EDGE = 3;
  localparam int ADDR_LAST_EDGE = 5;

  // Falling and rising edge counts, as seen in the counter after the edge
  localparam logic [3:0] CNT_HOLD = 4'h3;
  localparam logic [3:0] CNT_LAST = 4'hF;
  localparam logic [3:0] CNT_MSB = 4'h4;
  localparam logic [3:0] CNT_LSB = 4'hB;
  localparam logic [3:0] CNT_ADDR_LO = 4'h2;
  localparam logic [3:0] CNT_ADDR_LD = 4'h4;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [3:0] CNT_ZERO = 4'h0;

  // Reset image of the core synchroniser: select idle high, others low
  localparam logic [2:0] CORE_SYNC_RST = 3'h1;

  // Core side status towards the analog front end
  typedef struct packed {
    logic power_down;
    logic [1:0] mux_sel;
  } qad_core_stat_type;

endpackage : qad_pkg

// ===== hw/qad_serial_frame.sv
// Serial frame logic of a four channel 8-bit sampling converter.
// Assumes the front end presents the code of the selected channel on
// conv_code in the ref_clk domain; sclk comes from the host and may stop.
// Function
// - Sixteen clocks per conversion: three track, thirteen convert
// - Shut down while frame select is high
// - Drive serial output after frame select falls
// - Release serial output after frame select rises
// - New output bit after each falling clock edge
// - Address shifted in selects next conversion's channel
// - Track first three clocks, then hold sample
`timescale 1ns/1ps
module qad_serial_frame
  import qad_pkg::*;
(
  // Core clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Serial link from the host
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic dout,
  output logic dout_oe,
  // Analog front end
  input wire logic [DATA_BITS-1:0] conv_code,
  output qad_core_stat_type core_stat,
  output logic track
);

  // Core domain state
  logic [2:0] c_s1_ff, c_s2_ff, c_s3_ff, c_q_ff, nxt_c_q;
  logic wreq_ff, nxt_wreq;
  logic [DATA_BITS-1:0] pub_ff, nxt_pub;
  logic aack_ff, nxt_aack;
  logic [CH_BITS-1:0] mux_ff, nxt_mux;
  logic pd_ff, nxt_pd;
  logic cs_q, wack_q, areq_q;

  // Link domain state, rising edge side
  logic [1:0] l_s1_ff, l_s2_ff, l_s3_ff, l_q_ff, nxt_l_q;
  logic [CNT_BITS-1:0] rise_cnt_ff, nxt_rise_cnt;
  logic [CH_BITS-1:0] addr_sh_ff, nxt_addr_sh, chan_ff, nxt_chan;
  logic areq_ff, nxt_areq;
  logic wack_ff, nxt_wack;
  logic [DATA_BITS-1:0] word_ff, nxt_word;
  logic wreq_q, aack_q;

  // Link domain state, falling edge side
  logic [CNT_BITS-1:0] fall_cnt_ff, nxt_fall_cnt;
  logic [DATA_BITS-1:0] held_ff, nxt_held;
  logic track_ff, nxt_track;
  logic out_ff, nxt_out;
  logic [CNT_BITS-1:0] bit_idx;
  logic [DATA_BITS-1:0] word_now;

  assign cs_q = c_q_ff[0];
  assign wack_q = c_q_ff[1];
  assign areq_q = c_q_ff[2];
  assign wreq_q = l_q_ff[0];
  assign aack_q = l_q_ff[1];

  // Core next state: a level counts once stages two and three agree
  always_comb
  begin
    nxt_c_q = ((c_s2_ff ~^ c_s3_ff) & c_s3_ff) |
              ((c_s2_ff ^ c_s3_ff) & c_q_ff);
    nxt_pd = cs_q;
    nxt_wreq = wreq_ff;
    nxt_pub = pub_ff;
    // Four phase word handshake keeps pub_ff still while link reads it
    if (!wreq_ff && !wack_q)
    begin
      nxt_pub = conv_code;
      nxt_wreq = 1'b1;
    end
    else if (wreq_ff && wack_q)
      nxt_wreq = 1'b0;
    nxt_aack = aack_ff;
    nxt_mux = mux_ff;
    // Link holds chan_ff still while its request stands
    if (areq_q && !aack_ff)
    begin
      nxt_mux = chan_ff;
      nxt_aack = 1'b1;
    end
    else if (!areq_q)
      nxt_aack = 1'b0;
  end

  // Core registers
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      c_s1_ff <= CORE_SYNC_RST;
      c_s2_ff <= CORE_SYNC_RST;
      c_s3_ff <= CORE_SYNC_RST;
      c_q_ff <= CORE_SYNC_RST;
      pd_ff <= 1'b1;
      wreq_ff <= 1'b0;
      pub_ff <= '0;
      aack_ff <= 1'b0;
      mux_ff <= '0;
    end
    else
    begin
      c_s1_ff <= {areq_ff, wack_ff, cs_n};
      c_s2_ff <= c_s1_ff;
      c_s3_ff <= c_s2_ff;
      c_q_ff <= nxt_c_q;
      pd_ff <= nxt_pd;
      wreq_ff <= nxt_wreq;
      pub_ff <= nxt_pub;
      aack_ff <= nxt_aack;
      mux_ff <= nxt_mux;
    end
  end

  assign core_stat = '{power_down: pd_ff, mux_sel: mux_ff};

  // Rising edge next state: count, address capture, handshakes
  always_comb
  begin
    nxt_l_q = ((l_s2_ff ~^ l_s3_ff) & l_s3_ff) |
              ((l_s2_ff ^ l_s3_ff) & l_q_ff);
    nxt_rise_cnt = rise_cnt_ff + CNT_ONE; // wraps every 16
    nxt_addr_sh = addr_sh_ff;
    nxt_chan = chan_ff;
    nxt_areq = areq_ff;
    if (rise_cnt_ff >= CNT_ADDR_LO && rise_cnt_ff < CNT_ADDR_LD)
      nxt_addr_sh = {addr_sh_ff[0], din};
    if (rise_cnt_ff == CNT_ADDR_LD)
    begin
      nxt_chan = {addr_sh_ff[0], din};
      nxt_areq = 1'b1;
    end
    else if (aack_q)
      nxt_areq = 1'b0;
    nxt_wack = wack_ff;
    nxt_word = word_ff;
    if (wreq_q && !wack_ff)
    begin
      nxt_word = pub_ff;
      nxt_wack = 1'b1;
    end
    else if (!wreq_q)
      nxt_wack = 1'b0;
  end

  // Rising edge registers; the frame select ends all link state since
  // sclk may stand still between frames
  always_ff @(posedge sclk or posedge cs_n)
  begin
    if (cs_n)
    begin
      l_s1_ff <= '0;
      l_s2_ff <= '0;
      l_s3_ff <= '0;
      l_q_ff <= '0;
      rise_cnt_ff <= '0;
      addr_sh_ff <= '0;
      chan_ff <= '0;
      areq_ff <= 1'b0;
      wack_ff <= 1'b0;
      word_ff <= '0;
    end
    else
    begin
      l_s1_ff <= {aack_ff, wreq_ff};
      l_s2_ff <= l_s1_ff;
      l_s3_ff <= l_s2_ff;
      l_q_ff <= nxt_l_q;
      rise_cnt_ff <= nxt_rise_cnt;
      addr_sh_ff <= nxt_addr_sh;
      chan_ff <= nxt_chan;
      areq_ff <= nxt_areq;
      wack_ff <= nxt_wack;
      word_ff <= nxt_word;
    end
  end

  // Falling edge next state: track/hold and output bit sequencing
  always_comb
  begin
    nxt_fall_cnt = fall_cnt_ff + CNT_ONE;
    // Index from the count after this edge, so bit 0 goes out last
    bit_idx = CNT_LSB - nxt_fall_cnt;
    // Until the link acknowledges, the core keeps pub_ff still, so the
    // first group of a frame reads it here; the rising side is too late
    word_now = word_ff;
    if (wreq_q && !wack_ff)
      word_now = pub_ff;
    nxt_held = held_ff;
    nxt_track = track_ff;
    nxt_out = 1'b0; // leading and trailing zeros
    if (fall_cnt_ff == CNT_HOLD)
    begin
      nxt_held = word_now;
      nxt_track = 1'b0;
      nxt_out = word_now[DATA_BITS-1];
    end
    else if (fall_cnt_ff > CNT_HOLD && fall_cnt_ff < CNT_LSB)
      nxt_out = held_ff[bit_idx[2:0]];
    if (fall_cnt_ff == CNT_LAST)
      nxt_track = 1'b1; // next conversion tracks
  end

  // Falling edge registers
  always_ff @(negedge sclk or posedge cs_n)
  begin
    if (cs_n)
    begin
      fall_cnt_ff <= '0;
      held_ff <= '0;
      track_ff <= 1'b1;
      out_ff <= 1'b0;
    end
    else
    begin
      fall_cnt_ff <= nxt_fall_cnt;
      held_ff <= nxt_held;
      track_ff <= nxt_track;
      out_ff <= nxt_out;
    end
  end

  // Pin drive follows the select directly, so the line is released
  // without waiting for a clock that may already have stopped
  assign dout_oe = !cs_n;
  assign dout = out_ff;
  assign track = track_ff;

  // Checks
  chk_oe_follow: assert property (@(posedge ref_clk)
    disable iff (!reset_n) $fell(cs_n) |-> dout_oe)
    else $error("output not driven in frame");
  chk_oe_release: assert property (@(posedge ref_clk)
    disable iff (!reset_n) cs_n |-> !dout_oe)
    else $error("output driven outside frame");
  chk_power_down: assert property (@(posedge ref_clk)
    disable iff (!reset_n) cs_n [*5] |=> core_stat.power_down)
    else $error("no shutdown with select high");
  chk_frame_wrap: assert property (@(posedge sclk)
    disable iff (cs_n) rise_cnt_ff == CNT_LAST |=>
    rise_cnt_ff == CNT_ZERO && track_ff)
    else $error("next conversion did not start after 16");
  chk_track_hold: assert property (@(negedge sclk)
    disable iff (cs_n)
    track_ff == (fall_cnt_ff < CNT_MSB || fall_cnt_ff == CNT_ZERO))
    else $error("track phase wrong");
  chk_msb_first: assert property (@(negedge sclk)
    disable iff (cs_n) fall_cnt_ff == CNT_MSB |->
    out_ff == held_ff[DATA_BITS-1]
    ##1 out_ff == held_ff[DATA_BITS-2])
    else $error("result not sent MSB first");
  chk_zero_pad: assert property (@(negedge sclk)
    disable iff (cs_n) fall_cnt_ff > CNT_LSB |-> !out_ff)
    else $error("trailing bits not zero");
  chk_addr_req: assert property (@(posedge sclk)
    disable iff (cs_n) rise_cnt_ff == CNT_ADDR_LD |=> areq_ff)
    else $error("address not offered to core");
  chk_mux_ack: assert property (@(posedge ref_clk)
    disable iff (!reset_n) areq_q && !aack_ff |=>
    aack_ff && core_stat.mux_sel == $past(chan_ff))
    else $error("address not taken by core");

  cov_full_frame: cover property (@(posedge sclk)
    disable iff (cs_n) rise_cnt_ff == CNT_LAST);
  cov_power_down: cover property (@(posedge ref_clk)
    disable iff (!reset_n) $rose(core_stat.power_down));
  cov_mux_change: cover property (@(posedge ref_clk)
    disable iff (!reset_n) $changed(core_stat.mux_sel));
  cov_msb_one: cover property (@(negedge sclk)
    disable iff (cs_n) fall_cnt_ff == CNT_MSB && out_ff);

endmodule : qad_serial_frame
